/* File: design/usbh_ep0_handshake.sv */
// Endpoint 0 handshake logic between link, firmware and register I/O bridge
`timescale 1ns/100ps
`include "usbh_defines.svh"
module usbh_ep0_handshake
    import usbh_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire usbh_link_in_t            linkIn,
    input  wire logic [7:0]               setupByte,
    input  wire logic                     setupByteVld,
    output usbh_hs_t                      hsOut,
    output logic                          txValid,
    output logic      [7:0]               txByte,
    output logic                          txLast,
    output logic                          txZlp,
    input  wire logic                     mcuCtlWe,
    input  wire logic [7:0]               mcuCtlWdata,
    output logic      [7:0]               ctlHigh,
    output logic      [63:0]              setupCmd,
    input  wire logic                     mcuCntWe,
    input  wire logic [3:0]               mcuCntWdata,
    output logic      [3:0]               setupCnt,
    input  wire logic                     mcuBufWe,
    input  wire logic [`USBH_BUF_AW-1:0]  mcuBufAddr,
    input  wire logic [7:0]               mcuBufWdata,
    output logic      [7:0]               mcuBufRdata,
    input  wire logic                     ioAddrWe,
    input  wire logic [15:0]              ioAddrWdata,
    input  wire logic                     ioDataWe,
    input  wire logic [15:0]              ioDataWdata,
    output logic      [15:0]              ioAddr,
    output logic      [15:0]              ioData,
    output logic                          pbReq,
    output logic                          pbWrite,
    output logic      [13:0]              pbAddr,
    output logic      [15:0]              pbWdata,
    input  wire logic                     pbAck,
    input  wire logic [15:0]              pbRdata
);
    logic [7:0]  ctl_q, ctl_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        rxOn_q, rxOn_d;
    logic        lastNz_q, lastNz_d;
    logic [63:0] cmd_q, cmd_d;
    logic [2:0]  cmdIdx_q, cmdIdx_d;
    usbh_hs_t    hs_q, hs_d;
    usbh_tx_state_t txSt_q, txSt_d;
    logic [3:0]  txIdx_q, txIdx_d;
    logic [3:0]  txLen_q, txLen_d;
    logic        txValid_q, txValid_d, txLast_q, txLast_d, txZlp_q, txZlp_d;
    usbh_io_state_t ioSt_q, ioSt_d;
    logic [15:0] ioAddr_q, ioAddr_d, ioData_q, ioData_d;
    logic        bufWe;
    logic [3:0]  bufWrAddr;
    logic [7:0]  bufWrData;
    logic        busy, stallReq, rxByte;

    // Flag shorthands
    assign busy     = ctl_q[`USBH_BUSY_BIT];
    assign stallReq = ctl_q[`USBH_STALL_BIT];
    assign rxByte   = rxOn_q && linkIn.outByteVld;

    // Setup packet capture
    always_comb begin
        cmd_d    = cmd_q;
        cmdIdx_d = cmdIdx_q;
        if (setupByteVld) begin
            cmd_d[cmdIdx_q*8 +: 8] = setupByte;
            cmdIdx_d               = cmdIdx_q + 3'h1;
        end
        if (linkIn.setupDone) cmdIdx_d = 3'h0;
    end

    // Control flags, counter, OUT reception and handshakes
    always_comb begin
        ctl_d    = ctl_q;
        cnt_d    = cnt_q;
        rxOn_d   = rxOn_q;
        lastNz_d = lastNz_q;
        hs_d     = '0;
        if (mcuCtlWe) ctl_d = mcuCtlWdata; // Firmware clears handled flags, may request stall
        if (mcuCntWe) cnt_d = mcuCntWdata;
        if (linkIn.outToken && !rxOn_q) begin
            if (stallReq) hs_d.stall = 1'b1;
            else if (busy) hs_d.nak = 1'b1;
            else begin
                rxOn_d = 1'b1;
                cnt_d  = `USBH_CNT_OUT_BASE;
            end
        end
        if (rxByte && cnt_q != 4'h0) cnt_d = cnt_q - 4'h1;
        if (rxOn_q && linkIn.outEnd) begin
            rxOn_d   = 1'b0;
            hs_d.ack = 1'b1;
            if (cnt_q != `USBH_CNT_OUT_BASE || rxByte) begin
                ctl_d[`USBH_INT_BIT]  = 1'b1;
                ctl_d[`USBH_BUSY_BIT] = 1'b1;
                ctl_d[`USBH_OUT_BIT]  = 1'b1;
            end
        end
        if (linkIn.inToken && txSt_q == TX_IDLE) begin
            if (stallReq) hs_d.stall = 1'b1;
            else if (busy) hs_d.nak = 1'b1;
            else lastNz_d = (cnt_q != 4'h0);
        end
        if (linkIn.inAck && lastNz_q) begin
            lastNz_d              = 1'b0;
            ctl_d[`USBH_INT_BIT]  = 1'b1;
            ctl_d[`USBH_BUSY_BIT] = 1'b1;
            ctl_d[`USBH_IN_BIT]   = 1'b1;
        end
        // A new SETUP always wins and lifts a pending stall
        if (linkIn.setupDone) begin
            ctl_d[`USBH_INT_BIT]   = 1'b1;
            ctl_d[`USBH_BUSY_BIT]  = 1'b1;
            ctl_d[`USBH_SETUP_BIT] = 1'b1;
            ctl_d[`USBH_IN_BIT]    = 1'b1;
            ctl_d[`USBH_OUT_BIT]   = 1'b1;
            ctl_d[`USBH_STALL_BIT] = 1'b0;
            rxOn_d                 = 1'b0;
            lastNz_d               = 1'b0;
            hs_d.ack               = 1'b1;
        end
    end

    // Buffer write port: received bytes beat firmware writes
    always_comb begin
        bufWe     = mcuBufWe;
        bufWrAddr = mcuBufAddr;
        bufWrData = mcuBufWdata;
        if (rxByte && cnt_q != 4'h0) begin
            bufWe     = 1'b1;
            bufWrAddr = `USBH_CNT_OUT_BASE - cnt_q;
            bufWrData = linkIn.outByte;
        end
    end

    // IN data transmission
    always_comb begin
        txSt_d    = txSt_q;
        txIdx_d   = txIdx_q;
        txLen_d   = txLen_q;
        txValid_d = 1'b0;
        txLast_d  = 1'b0;
        txZlp_d   = 1'b0;
        unique case (txSt_q)
            TX_IDLE: begin
                if (linkIn.inToken && !stallReq && !busy && !linkIn.setupDone) begin
                    txIdx_d = 4'h0;
                    txLen_d = cnt_q;
                    txSt_d  = (cnt_q == 4'h0) ? TX_ZLP : TX_SEND;
                end
            end
            TX_SEND: begin
                txValid_d = 1'b1;
                txLast_d  = (txIdx_q == txLen_q - 4'h1);
                txIdx_d   = txIdx_q + 4'h1;
                if (txIdx_q == txLen_q - 4'h1) txSt_d = TX_IDLE;
            end
            TX_ZLP: begin
                txZlp_d = 1'b1;
                txSt_d  = TX_IDLE;
            end
        endcase
    end

    // Register I/O bridge onto the peripheral bus
    always_comb begin
        ioSt_d   = ioSt_q;
        ioAddr_d = ioAddr_q;
        ioData_d = ioData_q;
        unique case (ioSt_q)
            IO_IDLE: begin
                if (ioDataWe) ioData_d = ioDataWdata;
                if (ioAddrWe) begin
                    ioAddr_d = ioAddrWdata;
                    if (ioAddrWdata[`USBH_GO_BIT]) ioSt_d = IO_BUSY;
                end
            end
            IO_BUSY: begin
                ioAddr_d[`USBH_GO_BIT] = 1'b1;
                if (pbAck) begin
                    ioAddr_d[`USBH_GO_BIT] = 1'b0;
                    ioSt_d                 = IO_IDLE;
                    if (!ioAddr_q[`USBH_WR_BIT]) ioData_d = pbRdata;
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge clock) begin
        if (rst) begin
            ctl_q     <= `USBH_CTL_RESET;
            cnt_q     <= `USBH_CNT_RESET;
            rxOn_q    <= 1'b0;
            lastNz_q  <= 1'b0;
            cmd_q     <= 64'h0;
            cmdIdx_q  <= 3'h0;
            hs_q      <= '0;
            txSt_q    <= TX_IDLE;
            txIdx_q   <= 4'h0;
            txLen_q   <= 4'h0;
            txValid_q <= 1'b0;
            txLast_q  <= 1'b0;
            txZlp_q   <= 1'b0;
            ioSt_q    <= IO_IDLE;
            ioAddr_q  <= 16'h0;
            ioData_q  <= 16'h0;
        end else begin
            ctl_q     <= ctl_d;
            cnt_q     <= cnt_d;
            rxOn_q    <= rxOn_d;
            lastNz_q  <= lastNz_d;
            cmd_q     <= cmd_d;
            cmdIdx_q  <= cmdIdx_d;
            hs_q      <= hs_d;
            txSt_q    <= txSt_d;
            txIdx_q   <= txIdx_d;
            txLen_q   <= txLen_d;
            txValid_q <= txValid_d;
            txLast_q  <= txLast_d;
            txZlp_q   <= txZlp_d;
            ioSt_q    <= ioSt_d;
            ioAddr_q  <= ioAddr_d;
            ioData_q  <= ioData_d;
        end
    end

    usbh_setup_buf u_buf (
        .clock   (clock),
        .we      (bufWe),
        .wrAddr  (bufWrAddr),
        .wrData  (bufWrData),
        .rdAddrA (txIdx_q),
        .rdDataA (txByte),
        .rdAddrB (mcuBufAddr),
        .rdDataB (mcuBufRdata)
    );

    // Output drive, all from flip-flops
    assign hsOut    = hs_q;
    assign txValid  = txValid_q;
    assign txLast   = txLast_q;
    assign txZlp    = txZlp_q;
    assign ctlHigh  = ctl_q;
    assign setupCmd = cmd_q;
    assign setupCnt = cnt_q;
    assign ioAddr   = ioAddr_q;
    assign ioData   = ioData_q;
    assign pbReq    = (ioSt_q == IO_BUSY);
    assign pbWrite  = ioAddr_q[`USBH_WR_BIT];
    assign pbAddr   = ioAddr_q[13:0];
    assign pbWdata  = ioData_q;

    // Helper counting bytes handed out in the current IN packet
    logic [3:0] txSeen_q;
    always_ff @(posedge clock) begin
        if (rst || txSt_q == TX_IDLE) txSeen_q <= 4'h0;
        else if (txValid_d) txSeen_q <= txSeen_q + 4'h1;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_setup;
        linkIn.setupDone;
    endsequence
    sequence s_in_taken;
        txSt_q == TX_IDLE && linkIn.inToken && !stallReq && !busy
            && !linkIn.setupDone && cnt_q != 4'h0;
    endsequence

    a_setup_sets_flags: assert property (s_setup |=> ctl_q[4:0] == 5'h1f)
        else $error("Setup did not raise all flags");
    a_int_set_wins: assert property (s_setup and mcuCtlWe |=> ctl_q[`USBH_INT_BIT])
        else $error("Firmware clear lost a setup event");
    a_inack_in_flag: assert property (linkIn.inAck && lastNz_q && !mcuCtlWe
        |=> ctl_q[`USBH_IN_BIT] && ctl_q[`USBH_BUSY_BIT])
        else $error("IN ACK did not set IN flag");
    a_out_end_flag: assert property (rxOn_q && linkIn.outEnd && rxByte && !mcuCtlWe
        |=> ctl_q[`USBH_OUT_BIT] && ctl_q[`USBH_INT_BIT])
        else $error("OUT data did not set OUT flag");
    a_stall_answer: assert property (linkIn.inToken && txSt_q == TX_IDLE && stallReq
        && !linkIn.setupDone |=> hsOut.stall && !txValid ##1 !txValid)
        else $error("Stall request not answered with STALL");
    a_rx_count_down: assert property (rxByte && cnt_q != 4'h0 && !linkIn.setupDone
        |=> cnt_q == $past(cnt_q) - 4'h1)
        else $error("OUT byte did not decrement counter");
    a_tx_length: assert property (s_in_taken |-> ##[2:17] (txLast && txSeen_q == txLen_q))
        else $error("IN packet length differs from counter");
    a_io_busy_hold: assert property (ioSt_q == IO_BUSY |-> ioAddr_q[`USBH_GO_BIT])
        else $error("Go bit dropped during bus cycle");
    a_io_done: assert property (pbReq && pbAck |=> !ioAddr_q[`USBH_GO_BIT] && !pbReq)
        else $error("Go bit not cleared after bus cycle");
endmodule

/* File: shared/usbh_defines.svh */
// Constants for the endpoint 0 handshake block
// Behaviour
// - A SETUP, host ACK of a non-empty IN packet or a non-empty OUT data stage sets the interrupt and busy flags.
// - A finished SETUP packet sets the setup-arrived flag.
// - SETUP or host ACK of a non-empty IN packet sets the IN-stage flag.
// - SETUP or a non-empty OUT data stage sets the OUT-stage flag.
// - Firmware clears counter and sets stall bit; hardware then answers STALL.
// - Bridge holds address bit 15 high during a cycle, clears it after.
// - After OUT data, bytes received equal 14 minus the counter.
`ifndef USBH_DEFINES_SVH
`define USBH_DEFINES_SVH
`define USBH_INT_BIT   0
`define USBH_BUSY_BIT  1
`define USBH_SETUP_BIT 2
`define USBH_IN_BIT    3
`define USBH_OUT_BIT   4
`define USBH_STALL_BIT 5
`define USBH_CTL_RESET 8'h00
`define USBH_CNT_OUT_BASE 4'he
`define USBH_CNT_RESET 4'h0
`define USBH_BUF_AW    4
`define USBH_GO_BIT    15
`define USBH_WR_BIT    14
`endif

/* File: shared/usbh_pkg.sv */
// Types shared by the endpoint 0 handshake block
package usbh_pkg;
    typedef struct packed {
        logic       setupDone;   // Valid SETUP packet finished
        logic       inAck;       // Host ACKed our last IN packet
        logic       inToken;     // IN token addressed to endpoint 0
        logic       outToken;    // OUT token addressed to endpoint 0
        logic       outByteVld;  // OUT data byte strobe
        logic [7:0] outByte;     // OUT data byte
        logic       outEnd;      // OUT data packet finished, CRC good
    } usbh_link_in_t;
    typedef struct packed {
        logic       ack;
        logic       nak;
        logic       stall;
    } usbh_hs_t;
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_ZLP} usbh_tx_state_t;
    typedef enum logic {IO_IDLE, IO_BUSY} usbh_io_state_t;
endpackage

/* File: design/usbh_setup_buf.sv */
// Setup data buffer with two registered read ports
`timescale 1ns/100ps
`include "usbh_defines.svh"
module usbh_setup_buf
    import usbh_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     we,
    input  wire logic [`USBH_BUF_AW-1:0]  wrAddr,
    input  wire logic [7:0]               wrData,
    input  wire logic [`USBH_BUF_AW-1:0]  rdAddrA,
    output logic      [7:0]               rdDataA,
    input  wire logic [`USBH_BUF_AW-1:0]  rdAddrB,
    output logic      [7:0]               rdDataB
);
    logic [7:0] mem [0:(1<<`USBH_BUF_AW)-1];

    // Storage and registered reads
    always_ff @(posedge clock) begin
        if (we) begin
            mem[wrAddr] <= wrData;
        end
        rdDataA <= mem[rdAddrA];
        rdDataB <= mem[rdAddrB];
    end
endmodule

/* File: tb/usbh_pb_target.sv */
// Peripheral bus target model that answers register I/O cycles
`timescale 1ns/100ps
module usbh_pb_target (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [3:0]  waitCycles,
    input  wire logic        pbReq,
    input  wire logic        pbWrite,
    input  wire logic [13:0] pbAddr,
    input  wire logic [15:0] pbWdata,
    output logic             pbAck,
    output logic [15:0]      pbRdata
);
    logic [15:0] mem [16];
    logic [3:0]  cnt;
    logic        done;
    // Known contents so the bench can predict reads
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'h1000 + 16'(i);
        end
    end
    // Waits, acks once per request, then waits for the request to drop
    always @(posedge clock) begin
        pbAck <= 1'b0;
        pbRdata <= ~pbRdata; // Data is only meaningful with the ack
        if (rst) begin
            cnt <= 4'h0;
            done <= 1'b0;
            pbRdata <= 16'h5a5a;
        end else if (!pbReq) begin
            cnt <= 4'h0;
            done <= 1'b0;
        end else if (!done && cnt >= waitCycles) begin
            pbAck <= 1'b1;
            done <= 1'b1;
            if (pbWrite) begin
                mem[pbAddr[3:0]] <= pbWdata;
            end else begin
                pbRdata <= mem[pbAddr[3:0]];
            end
        end else if (!done) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

/* File: tb/usbh_ep0_handshake_tb.sv */
// Self-checking bench for the endpoint 0 handshake block
`timescale 1ns/100ps
module usbh_ep0_handshake_tb;
    import usbh_pkg::*;
    logic clock, rst, setupByteVld, mcuCtlWe, mcuCntWe, mcuBufWe, ioAddrWe, ioDataWe;
    logic txValid, txLast, txZlp, pbReq, pbWrite, pbAck;
    logic [7:0] setupByte, mcuCtlWdata, ctlHigh, mcuBufWdata, mcuBufRdata, txByte, b;
    logic [3:0] mcuCntWdata, setupCnt, mcuBufAddr, waitCycles, a;
    logic [15:0] ioAddrWdata, ioDataWdata, ioAddr, ioData, pbWdata, pbRdata, w;
    logic [13:0] pbAddr;
    logic [63:0] setupCmd, cmd;
    logic [15:0] adr, txw;
    int total, sent, n;
    logic [7:0] outBytes [3];
    usbh_link_in_t linkIn;
    usbh_hs_t hsOut;
    logic [8:0] expQ [$];
    int failures = 0, comparisons = 0, cycles = 0, seed = 56;
    usbh_ep0_handshake dut (.clock(clock), .rst(rst), .linkIn(linkIn), .setupByte(setupByte),
        .setupByteVld(setupByteVld), .hsOut(hsOut), .txValid(txValid), .txByte(txByte),
        .txLast(txLast), .txZlp(txZlp), .mcuCtlWe(mcuCtlWe), .mcuCtlWdata(mcuCtlWdata),
        .ctlHigh(ctlHigh), .setupCmd(setupCmd), .mcuCntWe(mcuCntWe),
        .mcuCntWdata(mcuCntWdata), .setupCnt(setupCnt), .mcuBufWe(mcuBufWe),
        .mcuBufAddr(mcuBufAddr), .mcuBufWdata(mcuBufWdata), .mcuBufRdata(mcuBufRdata),
        .ioAddrWe(ioAddrWe), .ioAddrWdata(ioAddrWdata), .ioDataWe(ioDataWe),
        .ioDataWdata(ioDataWdata), .ioAddr(ioAddr), .ioData(ioData), .pbReq(pbReq),
        .pbWrite(pbWrite), .pbAddr(pbAddr), .pbWdata(pbWdata), .pbAck(pbAck),
        .pbRdata(pbRdata));
    usbh_pb_target target (.clock(clock), .rst(rst), .waitCycles(waitCycles), .pbReq(pbReq),
        .pbWrite(pbWrite), .pbAddr(pbAddr), .pbWdata(pbWdata), .pbAck(pbAck),
        .pbRdata(pbRdata));
    // Clock and hang guard
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    // Collects handshake pulses over a short window
    task automatic seeHs(input logic [2:0] exp);
        logic [2:0] seen;
        seen = 3'b000;
        for (int i = 0; i < 4; i++) begin
            seen = seen | hsOut;
            tick();
        end
        check({13'h0, seen}, {13'h0, exp}, "handshake");
    endtask
    task automatic fw(input logic [7:0] ctl, input logic [3:0] cnt);
        mcuCntWdata = cnt;
        mcuCntWe = 1'b1;
        tick();
        mcuCntWe = 1'b0;
        mcuCtlWdata = ctl;
        mcuCtlWe = 1'b1;
        tick();
        mcuCtlWe = 1'b0;
    endtask
    // Sends an eight-byte SETUP packet; clr adds a firmware clear in the same cycle
    task automatic setupPkt(input logic [63:0] c, input logic clr);
        for (int i = 0; i < 8; i++) begin
            setupByte = c[8*i +: 8];
            setupByteVld = 1'b1;
            tick();
        end
        setupByteVld = 1'b0;
        mcuCtlWdata = 8'h00;
        mcuCtlWe = clr;
        linkIn.setupDone = 1'b1;
        tick();
        linkIn.setupDone = 1'b0;
        mcuCtlWe = 1'b0;
        seeHs(3'b100);
        check({8'h0, ctlHigh}, 16'h1f, "setup flags");
    endtask
    task automatic token(input logic isOut);
        linkIn.inToken = !isOut;
        linkIn.outToken = isOut;
        tick();
        linkIn.inToken = 1'b0;
        linkIn.outToken = 1'b0;
    endtask
    task automatic drain();
        for (int k = 0; k < 12 && expQ.size() > 0; k++) tick();
        check(16'(expQ.size()), 16'h0, "bytes left");
    endtask
    // Starts an I/O cycle and polls the go bit under a bound
    task automatic ioCycle(input logic [15:0] addr);
        ioAddrWdata = addr;
        ioAddrWe = 1'b1;
        tick();
        ioAddrWe = 1'b0;
        tick();
        check({14'h0, ioAddr[15], pbReq}, 16'h3, "busy");
        for (int k = 0; k < 20 && ioAddr[15] !== 1'b0; k++) tick();
        check(ioAddr, {1'b0, addr[14:0]}, "go cleared");
    endtask
    // Watches the IN stream and compares against the oldest note
    always @(posedge clock) begin
        if (!rst && (txValid === 1'b1 || txZlp === 1'b1)) begin
            txw = {7'h0, txZlp | txLast, txValid ? txByte : 8'h00};
            check(txw, {7'h0, expQ.size() > 0 ? expQ.pop_front() : 9'h1ff}, "tx");
        end
    end
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        linkIn = '0;
        {setupByte, setupByteVld, mcuCtlWe, mcuCtlWdata, mcuCntWe, mcuCntWdata} = '0;
        {mcuBufWe, mcuBufAddr, mcuBufWdata, ioAddrWe, ioAddrWdata, ioDataWe, ioDataWdata} = '0;
        waitCycles = 4'h0;
        repeat (3) tick();
        rst = 1'b0;
        check({ctlHigh, 4'h0, setupCnt}, 16'h0, "reset");
        // SETUP packet sets all request flags and stores the command
        cmd = {$random(seed), $random(seed)};
        cmd[31] = 1'b0;
        cmd[7] = 1'b1;
        setupPkt(cmd, 1'b0);
        for (int i = 0; i < 4; i++) check(setupCmd[16*i +: 16], cmd[16*i +: 16], "cmd");
        $display("test setup finished");
        // IN data in chunks, total from setup bytes 6 and 7, host ack after each
        total = setupCmd[63:48] % 6 + 2;
        for (sent = 0; sent < total; sent += n) begin
            n = (total - sent > 4) ? 4 : total - sent;
            for (int i = 0; i < n; i++) begin
                b = 8'($random(seed));
                mcuBufAddr = 4'(i);
                mcuBufWdata = b;
                mcuBufWe = 1'b1;
                expQ.push_back({i == n - 1, b});
                tick();
            end
            mcuBufWe = 1'b0;
            fw(8'h00, 4'(n));
            token(1'b0);
            drain();
            linkIn.inAck = 1'b1;
            tick();
            linkIn.inAck = 1'b0;
            tick();
            check({8'h0, ctlHigh}, 16'h0b, "in ack flags");
        end
        // Zero-length packet, whose ack sets nothing
        fw(8'h00, 4'h0);
        expQ.push_back(9'h100);
        token(1'b0);
        drain();
        linkIn.inAck = 1'b1;
        tick();
        linkIn.inAck = 1'b0;
        tick();
        check({8'h0, ctlHigh}, 16'h00, "empty ack");
        $display("test in finished");
        // Busy gives NAK, stall request gives STALL, for both token kinds
        for (int t = 0; t < 2; t++) begin
            fw(8'h02, 4'h0);
            token(t[0]);
            seeHs(3'b010);
            fw(8'h20, 4'h0);
            token(t[0]);
            seeHs(3'b001);
        end
        $display("test refuse finished");
        // OUT data of three bytes, last one with the end strobe
        fw(8'h00, 4'h0);
        token(1'b1);
        for (int i = 0; i < 3; i++) begin
            outBytes[i] = 8'($random(seed));
            linkIn.outByte = outBytes[i];
            linkIn.outByteVld = 1'b1;
            linkIn.outEnd = (i == 2);
            tick();
        end
        linkIn.outByteVld = 1'b0;
        linkIn.outEnd = 1'b0;
        seeHs(3'b100);
        check({8'h0, ctlHigh}, 16'h13, "out flags");
        check({12'h0, setupCnt}, 16'd11, "out count");
        for (int i = 0; i < 3; i++) begin
            mcuBufAddr = 4'(i);
            tick();
            tick();
            check({8'h0, mcuBufRdata}, {8'h0, outBytes[i]}, "out byte");
        end
        $display("test out finished");
        // Register I/O read, then write and read back, prompt and slow target
        for (int r = 0; r < 2; r++) begin
            adr = setupCmd[31:16] ^ 16'(r * 9);
            a = adr[3:0];
            waitCycles = r ? 4'h7 : 4'h0;
            ioCycle({1'b1, ~setupCmd[7], adr[13:0]});
            check(ioData, 16'h1000 + {12'h0, a}, "io read");
            w = 16'($random(seed));
            ioDataWdata = w;
            ioDataWe = 1'b1;
            tick();
            ioDataWe = 1'b0;
            ioCycle({2'b11, adr[13:0]});
            ioCycle({2'b10, adr[13:0]});
            check(ioData, w, "io readback");
        end
        $display("test io finished");
        // Two no-data requests walk the device state; the second meets a firmware clear
        for (int k = 0; k < 2; k++) begin
            setupPkt({$random(seed), $random(seed)}, k[0]);
            fw(8'h00, 4'h0);
            check({ctlHigh, 4'h0, setupCnt}, 16'h0, "no data done");
        end
        $display("test enumerate finished");
        report_and_stop();
    end
endmodule
